// ===== adtc_host_model.sv
// host controller and axis pin model on the far side of the trace block
`timescale 1ns/1ps
module adtc_host_model (
  // clock
  input wire logic clk,
  // shared memory word write
  output logic [12:0] host_addr,
  output logic [15:0] host_wdata,
  output logic host_wr,
  // per-axis pins
  output logic [2:0] axis_start,
  output logic [2:0] axis_error
);
  // idle values at time zero
  initial begin
    host_addr = 13'h0000;
    host_wdata = 16'h0000;
    host_wr = 1'b0;
    axis_start = 3'h0;
    axis_error = 3'h0;
  end

  // one-cycle memory write; released bus shows inverted data, not the last value
  task automatic mem_write(input logic [12:0] a, input logic [15:0] d);
    @(posedge clk);
    host_addr <= a;
    host_wdata <= d;
    host_wr <= 1'b1;
    @(posedge clk);
    host_wr <= 1'b0;
    host_addr <= ~a;
    host_wdata <= ~d;
  endtask

  // level change on start and error pins after an edge
  task automatic set_pins(input logic [2:0] s, input logic [2:0] e);
    @(posedge clk);
    axis_start <= s;
    axis_error <= e;
  endtask
endmodule // adtc_host_model

// ===== adtc_pkg.sv
// shared constants of the axis data trace capture block
package adtc_pkg;
  // geometry
  localparam int NUM_AXES = 3;
  localparam int NUM_CH = 4;
  localparam int DATA_W = 16;
  localparam int DEPTH = 8192;
  localparam int ADDR_W = 13;
  localparam int CNT_W = 14;
  // timing: one interval unit in ms, clock period in ns
  localparam real UNIT_MS = 3.555;
  localparam real CLK_NS = 40.0;
  localparam int UNIT_CYCLES = int'($floor(UNIT_MS * 1.0e6 / CLK_NS));
  localparam int UNIT_W = 17;
  // programming limits
  localparam logic [8:0] INTERVAL_MIN = 9'h001;
  localparam logic [8:0] INTERVAL_MAX = 9'h100;
  localparam logic [13:0] POINTS_MIN = 14'h0001;
  localparam logic [13:0] POINTS_MAX = 14'h2000;
  // shared memory word that the host writes to trigger, and the value it writes
  localparam logic [12:0] HOST_TRIG_WORD = 13'd5050;
  localparam logic [15:0] HOST_TRIG_VAL = 16'h0001;
  // register byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CFG = 8'h04;
  localparam logic [7:0] REG_INTERVAL = 8'h08;
  localparam logic [7:0] REG_POINTS = 8'h0c;
  localparam logic [7:0] REG_CHSEL = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_COUNT = 8'h18;
  localparam logic [7:0] REG_IRQ_STAT = 8'h1c;
  localparam logic [7:0] REG_IRQ_MASK = 8'h20;
  localparam logic [7:0] REG_RDADDR = 8'h24;
  localparam logic [7:0] REG_RDLO = 8'h28;
  localparam logic [7:0] REG_RDHI = 8'h2c;
  // field positions
  localparam int CTRL_START = 0;
  localparam int CTRL_STOP = 1;
  localparam int CFG_TRIG_LSB = 0;
  localparam int CFG_STOP_LSB = 2;
  localparam int CFG_AXEN_LSB = 4;
  localparam int CFG_REDUCED = 7;
  localparam int IRQ_ACTIVE = 0;
  localparam int IRQ_DONE = 1;
  localparam int IRQ_ERRSTOP = 2;
  // reset values
  localparam logic [7:0] CFG_RST = 8'h10;
  localparam logic [19:0] CHSEL_RST = 20'h00000;
  // trigger, stop and quantity encodings
  typedef enum logic [1:0] {TRIG_UNCOND, TRIG_START_SIG, TRIG_ON_HOST_WRITE, TRIG_RSVD} adtc_trig_t;
  typedef enum logic [1:0] {STOP_FULL, STOP_POINTS, STOP_ERROR, STOP_REQUEST} adtc_stop_t;
  localparam logic [2:0] Q_POS_CMD = 3'h0;
  localparam logic [2:0] Q_SPEED = 3'h1;
  localparam logic [2:0] Q_CURRENT = 3'h2;
  localparam logic [2:0] Q_SPEED_CMD = 3'h3;
  localparam logic [2:0] Q_FOLLOW_ERR = 3'h4;
  localparam logic [2:0] REDUCED_AXEN = 3'h3;
endpackage

// ===== adtc_sample_mem.sv
// trace sample storage, one write port and one registered read port
`timescale 1ns/1ps
module adtc_sample_mem (
  // clock
  input wire logic clk,
  // write side
  input wire logic wr_en,
  input wire logic [adtc_pkg::ADDR_W-1:0] wr_addr,
  input wire logic [adtc_pkg::NUM_CH*adtc_pkg::DATA_W-1:0] wr_data,
  // read side
  input wire logic [adtc_pkg::ADDR_W-1:0] rd_addr,
  output logic [adtc_pkg::NUM_CH*adtc_pkg::DATA_W-1:0] rd_data
);
  logic [adtc_pkg::NUM_CH*adtc_pkg::DATA_W-1:0] mem [adtc_pkg::DEPTH];

  // store one aligned sample of all channels, read back one cycle later
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule // adtc_sample_mem

// ===== adtc_trace.sv
// trace capture: interval sampling, per-axis triggers, stop conditions, readout
// How it works
// - one sample per interval; interval 1..256 units of 3.555 ms each.
// - start-signal trigger: capture begins when the axis start signal goes active.
// - host writes 1 to shared word 5050; capture then begins.
// - unconditional trigger: capture begins right on the start command.
// - stop-on-full ends capture when the sample storage is completely filled.
// - point-count stop ends capture after programmed samples, 1..8192.
// - stop-on-error ends capture when a traced axis raises an error.
// - endless mode stops only on request; a request stops any mode.
// - each channel picks one axis quantity among five kinds.
// - after start wait for trigger; active once any enabled axis triggered.
// - no stop-condition end while an enabled axis still waits for trigger.
// - after the end samples are readable; untriggered axes are marked invalid.
// - reduced variant: two axes, speed command, stop-on-full, two triggers only.
//
// The implementer's own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module adtc_trace #(
  parameter int UNIT_CYCLES = adtc_pkg::UNIT_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // host shared memory word port
  input wire logic [12:0] host_addr,
  input wire logic [15:0] host_wdata,
  input wire logic host_wr,
  // per-axis quantities, axis 0 in the low bits
  input wire logic [47:0] pos_cmd,
  input wire logic [47:0] motor_speed,
  input wire logic [47:0] motor_current,
  input wire logic [47:0] speed_cmd,
  input wire logic [47:0] follow_err,
  // per-axis pins
  input wire logic [2:0] axis_start,
  input wire logic [2:0] axis_error,
  // status
  output logic tracing,
  output logic irq
);
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_RUN, ST_DONE} adtc_state_t;
  localparam int NQ = adtc_pkg::DATA_W;

  // pick one quantity of one axis
  function automatic logic [15:0] pick(input logic [1:0] ax, input logic [2:0] q,
                                       input logic [47:0] p, input logic [47:0] s,
                                       input logic [47:0] c, input logic [47:0] sc,
                                       input logic [47:0] fe);
    logic [47:0] src;
    src = p;
    case (q)
      adtc_pkg::Q_SPEED: src = s;
      adtc_pkg::Q_CURRENT: src = c;
      adtc_pkg::Q_SPEED_CMD: src = sc;
      adtc_pkg::Q_FOLLOW_ERR: src = fe;
      default: src = p;
    endcase
    pick = (ax < 2'd3) ? src[ax*NQ +: NQ] : 16'h0000;
  endfunction

  // clamp a value into a range
  function automatic logic [13:0] clamp(input logic [13:0] v, input logic [13:0] lo,
                                        input logic [13:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // pin synchronisers: three stages, accept a change once stages two and three agree
  logic [2:0] st_s1_r, st_s2_r, st_s3_r, st_f_r, st_f_nxt;
  logic [2:0] er_s1_r, er_s2_r, er_s3_r, er_f_r, er_f_nxt;
  always_comb begin
    st_f_nxt = (st_s2_r ~^ st_s3_r) & st_s3_r | ~(st_s2_r ~^ st_s3_r) & st_f_r;
    er_f_nxt = (er_s2_r ~^ er_s3_r) & er_s3_r | ~(er_s2_r ~^ er_s3_r) & er_f_r;
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_s1_r <= 3'h0;
      st_s2_r <= 3'h0;
      st_s3_r <= 3'h0;
      st_f_r <= 3'h0;
      er_s1_r <= 3'h0;
      er_s2_r <= 3'h0;
      er_s3_r <= 3'h0;
      er_f_r <= 3'h0;
    end else begin
      st_s1_r <= axis_start;
      st_s2_r <= st_s1_r;
      st_s3_r <= st_s2_r;
      st_f_r <= st_f_nxt;
      er_s1_r <= axis_error;
      er_s2_r <= er_s1_r;
      er_s3_r <= er_s2_r;
      er_f_r <= er_f_nxt;
    end
  end

  // configuration registers and the effective view under the reduced variant
  logic [7:0] cfg_r, cfg_nxt;
  logic [8:0] interval_r, interval_nxt;
  logic [13:0] points_r, points_nxt;
  logic [19:0] chsel_r, chsel_nxt;
  logic [2:0] irq_mask_r, irq_mask_nxt;
  logic [12:0] rdaddr_r, rdaddr_nxt;
  logic reduced;
  logic [2:0] axen;
  adtc_pkg::adtc_trig_t trig_mode;
  adtc_pkg::adtc_stop_t stop_mode;
  logic wr_ctrl, start_cmd, stop_cmd, host_trig;
  logic [13:0] ivl_clamp;
  assign reduced = cfg_r[adtc_pkg::CFG_REDUCED];
  assign axen = cfg_r[adtc_pkg::CFG_AXEN_LSB +: 3] & (reduced ? adtc_pkg::REDUCED_AXEN : 3'h7);
  always_comb begin
    trig_mode = adtc_pkg::adtc_trig_t'(cfg_r[adtc_pkg::CFG_TRIG_LSB +: 2]);
    stop_mode = adtc_pkg::adtc_stop_t'(cfg_r[adtc_pkg::CFG_STOP_LSB +: 2]);
    if (reduced) begin
      stop_mode = adtc_pkg::STOP_FULL;
      if (trig_mode != adtc_pkg::TRIG_START_SIG) begin
        trig_mode = adtc_pkg::TRIG_UNCOND;
      end
    end
  end
  assign wr_ctrl = reg_wr && (reg_addr == adtc_pkg::REG_CTRL);
  assign start_cmd = wr_ctrl && reg_wdata[adtc_pkg::CTRL_START];
  assign stop_cmd = wr_ctrl && reg_wdata[adtc_pkg::CTRL_STOP];
  assign host_trig = host_wr && (host_addr == adtc_pkg::HOST_TRIG_WORD)
                     && (host_wdata == adtc_pkg::HOST_TRIG_VAL);
  // interval setting held to its legal range
  assign ivl_clamp = clamp({5'h00, reg_wdata[8:0]}, 14'(adtc_pkg::INTERVAL_MIN),
                           14'(adtc_pkg::INTERVAL_MAX));

  // register writes
  always_comb begin
    cfg_nxt = cfg_r;
    interval_nxt = interval_r;
    points_nxt = points_r;
    chsel_nxt = chsel_r;
    irq_mask_nxt = irq_mask_r;
    rdaddr_nxt = rdaddr_r;
    if (reg_wr) begin
      if (reg_addr == adtc_pkg::REG_CFG) begin
        cfg_nxt = reg_wdata[7:0];
      end else if (reg_addr == adtc_pkg::REG_INTERVAL) begin
        interval_nxt = ivl_clamp[8:0];
      end else if (reg_addr == adtc_pkg::REG_POINTS) begin
        points_nxt = clamp(reg_wdata[13:0], adtc_pkg::POINTS_MIN, adtc_pkg::POINTS_MAX);
      end else if (reg_addr == adtc_pkg::REG_CHSEL) begin
        chsel_nxt = reg_wdata[19:0];
      end else if (reg_addr == adtc_pkg::REG_IRQ_MASK) begin
        irq_mask_nxt = reg_wdata[2:0];
      end else if (reg_addr == adtc_pkg::REG_RDADDR) begin
        rdaddr_nxt = reg_wdata[12:0];
      end
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg_r <= adtc_pkg::CFG_RST;
      interval_r <= adtc_pkg::INTERVAL_MIN;
      points_r <= adtc_pkg::POINTS_MAX;
      chsel_r <= adtc_pkg::CHSEL_RST;
      irq_mask_r <= 3'h0;
      rdaddr_r <= 13'h0000;
    end else begin
      cfg_r <= cfg_nxt;
      interval_r <= interval_nxt;
      points_r <= points_nxt;
      chsel_r <= chsel_nxt;
      irq_mask_r <= irq_mask_nxt;
      rdaddr_r <= rdaddr_nxt;
    end
  end

  // capture engine: state, per-axis trigger marks, time base, sample count
  adtc_state_t state_r, state_nxt;
  logic [2:0] trig_r, trig_nxt, waiting;
  logic [16:0] unit_r, unit_nxt;
  logic [8:0] ivl_r, ivl_nxt;
  logic [13:0] count_r, count_nxt;
  logic tick, full, stop_hit, err_hit, wr_en;
  logic [63:0] sample;
  logic [2:0] stat_r, stat_nxt, ev;
  assign waiting = axen & ~trig_r;
  assign full = (count_r == 14'(adtc_pkg::DEPTH));
  assign tick = (unit_r == 17'(UNIT_CYCLES - 1)) && (ivl_r == interval_r - 9'h001);
  assign wr_en = (state_r == ST_RUN) && tick && !full;
  assign err_hit = |(er_f_r & trig_r & axen);
  always_comb begin
    stop_hit = 1'b0;
    case (stop_mode)
      adtc_pkg::STOP_FULL: stop_hit = full || (count_r == 14'(adtc_pkg::DEPTH - 1) && wr_en);
      adtc_pkg::STOP_POINTS: stop_hit = (count_nxt >= points_r);
      adtc_pkg::STOP_ERROR: stop_hit = err_hit;
      default: stop_hit = 1'b0;
    endcase
  end
  // one sample word, untriggered axes stored as zero
  always_comb begin
    for (int c = 0; c < adtc_pkg::NUM_CH; c++) begin
      sample[c*NQ +: NQ] = (chsel_r[c*5 +: 2] != 2'h3) && trig_r[chsel_r[c*5 +: 2]] ?
        pick(chsel_r[c*5 +: 2] & (reduced ? 2'h1 : 2'h3),
             reduced ? adtc_pkg::Q_SPEED_CMD : chsel_r[c*5+2 +: 3],
             pos_cmd, motor_speed, motor_current, speed_cmd, follow_err) : 16'h0000;
    end
  end
  always_comb begin
    state_nxt = state_r;
    trig_nxt = trig_r;
    count_nxt = count_r + (wr_en ? 14'h0001 : 14'h0000);
    unit_nxt = (unit_r == 17'(UNIT_CYCLES - 1)) ? 17'h00000 : unit_r + 17'h00001;
    ivl_nxt = ivl_r;
    if (unit_r == 17'(UNIT_CYCLES - 1)) begin
      ivl_nxt = (ivl_r == interval_r - 9'h001) ? 9'h000 : ivl_r + 9'h001;
    end
    ev = 3'h0;
    if (state_r == ST_WAIT || state_r == ST_RUN) begin
      case (trig_mode)
        adtc_pkg::TRIG_START_SIG: trig_nxt = trig_r | (st_f_r & axen);
        adtc_pkg::TRIG_ON_HOST_WRITE: trig_nxt = trig_r | (host_trig ? axen : 3'h0);
        default: trig_nxt = trig_r | axen;
      endcase
    end
    case (state_r)
      ST_WAIT: begin
        if (stop_cmd) begin
          state_nxt = ST_DONE;
          ev[adtc_pkg::IRQ_DONE] = 1'b1;
        end else if (|trig_nxt) begin
          state_nxt = ST_RUN;
          ev[adtc_pkg::IRQ_ACTIVE] = 1'b1;
          unit_nxt = 17'h00000;
          ivl_nxt = 9'h000;
        end
      end
      ST_RUN: begin
        if (stop_cmd || (stop_hit && waiting == 3'h0)) begin
          state_nxt = ST_DONE;
          ev[adtc_pkg::IRQ_DONE] = 1'b1;
          ev[adtc_pkg::IRQ_ERRSTOP] = !stop_cmd && (stop_mode == adtc_pkg::STOP_ERROR);
        end
      end
      default: begin
        if (start_cmd) begin
          state_nxt = ST_WAIT;
          trig_nxt = 3'h0;
          count_nxt = 14'h0000;
        end
      end
    endcase
    // sticky events, set wins over a write-one clear
    stat_nxt = stat_r;
    if (reg_wr && reg_addr == adtc_pkg::REG_IRQ_STAT) begin
      stat_nxt = stat_r & ~reg_wdata[2:0];
    end
    stat_nxt = stat_nxt | ev;
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_IDLE;
      trig_r <= 3'h0;
      unit_r <= 17'h00000;
      ivl_r <= 9'h000;
      count_r <= 14'h0000;
      stat_r <= 3'h0;
    end else begin
      state_r <= state_nxt;
      trig_r <= trig_nxt;
      unit_r <= unit_nxt;
      ivl_r <= ivl_nxt;
      count_r <= count_nxt;
      stat_r <= stat_nxt;
    end
  end
  assign tracing = (state_r == ST_RUN);
  assign irq = |(stat_r & irq_mask_r);

  // sample storage
  logic [63:0] mem_q;
  adtc_sample_mem u_mem (
    .clk(clk),
    .wr_en(wr_en),
    .wr_addr(count_r[12:0]),
    .wr_data(sample),
    .rd_addr(rdaddr_r),
    .rd_data(mem_q)
  );

  // register read, answer one cycle after the strobe
  logic [31:0] rdata_r, rdata_nxt;
  logic readable;
  assign readable = (state_r == ST_DONE);
  always_comb begin
    rdata_nxt = 32'h00000000;
    if (reg_rd) begin
      if (reg_addr == adtc_pkg::REG_CFG) begin
        rdata_nxt = {24'h000000, cfg_r};
      end else if (reg_addr == adtc_pkg::REG_INTERVAL) begin
        rdata_nxt = {23'h000000, interval_r};
      end else if (reg_addr == adtc_pkg::REG_POINTS) begin
        rdata_nxt = {18'h00000, points_r};
      end else if (reg_addr == adtc_pkg::REG_CHSEL) begin
        rdata_nxt = {12'h000, chsel_r};
      end else if (reg_addr == adtc_pkg::REG_STATUS) begin
        rdata_nxt = {26'h0000000, trig_r & axen, 2'(state_r), |waiting};
      end else if (reg_addr == adtc_pkg::REG_COUNT) begin
        rdata_nxt = {18'h00000, count_r};
      end else if (reg_addr == adtc_pkg::REG_IRQ_STAT) begin
        rdata_nxt = {29'h00000000, stat_r};
      end else if (reg_addr == adtc_pkg::REG_IRQ_MASK) begin
        rdata_nxt = {29'h00000000, irq_mask_r};
      end else if (reg_addr == adtc_pkg::REG_RDADDR) begin
        rdata_nxt = {19'h00000, rdaddr_r};
      end else if (reg_addr == adtc_pkg::REG_RDLO) begin
        rdata_nxt = readable ? mem_q[31:0] : 32'h00000000;
      end else if (reg_addr == adtc_pkg::REG_RDHI) begin
        rdata_nxt = readable ? mem_q[63:32] : 32'h00000000;
      end
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_r <= 32'h00000000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end
  assign reg_rdata = rdata_r;

  // checks
  AST_TICK_WRITES: assert property (@(posedge clk) disable iff (!nrst)
    wr_en |-> ##1 count_r == $past(count_r) + 14'h0001)
    else $error("sample write did not advance the count");
  AST_START_TRIG: assert property (@(posedge clk) disable iff (!nrst)
    state_r == ST_WAIT && trig_mode == adtc_pkg::TRIG_START_SIG && |(st_f_r & axen) && !stop_cmd
    |=> state_r == ST_RUN)
    else $error("start signal did not begin capture");
  AST_HOST_TRIG: assert property (@(posedge clk) disable iff (!nrst)
    state_r == ST_WAIT && trig_mode == adtc_pkg::TRIG_ON_HOST_WRITE && host_trig && axen != 3'h0
    && !stop_cmd |=> tracing)
    else $error("host write did not begin capture");
  AST_UNCOND: assert property (@(posedge clk) disable iff (!nrst)
    state_r != ST_WAIT && state_r != ST_RUN && start_cmd && trig_mode == adtc_pkg::TRIG_UNCOND
    && axen != 3'h0 ##1 !stop_cmd |=> tracing)
    else $error("unconditional trigger did not start at once");
  AST_FULL_STOP: assert property (@(posedge clk) disable iff (!nrst)
    tracing && stop_mode == adtc_pkg::STOP_FULL && waiting == 3'h0
    && (full || (wr_en && count_r == 14'(adtc_pkg::DEPTH - 1))) |=> state_r == ST_DONE && full)
    else $error("full storage did not end capture");
  AST_POINTS: assert property (@(posedge clk) disable iff (!nrst)
    tracing && stop_mode == adtc_pkg::STOP_POINTS && waiting == 3'h0 && count_nxt >= points_r
    |=> state_r == ST_DONE)
    else $error("point count did not end capture");
  AST_ERR_STOP: assert property (@(posedge clk) disable iff (!nrst)
    tracing && stop_mode == adtc_pkg::STOP_ERROR && err_hit && waiting == 3'h0 && !stop_cmd
    |=> state_r == ST_DONE && stat_r[adtc_pkg::IRQ_ERRSTOP])
    else $error("axis error did not end capture");
  AST_STOP_REQ: assert property (@(posedge clk) disable iff (!nrst)
    tracing && stop_cmd |=> state_r == ST_DONE ##1 state_r == ST_DONE || $past(start_cmd))
    else $error("stop request did not end capture");
  AST_WAITING_HOLD: assert property (@(posedge clk) disable iff (!nrst)
    tracing && !stop_cmd && waiting != 3'h0 |=> state_r == ST_RUN)
    else $error("capture ended while an axis was waiting");
  AST_REDUCED: assert property (@(posedge clk) disable iff (!nrst)
    reduced |-> !axen[2] && stop_mode == adtc_pkg::STOP_FULL)
    else $error("reduced variant limits not kept");
endmodule // adtc_trace

// ===== adtc_trace_tb.sv
// self-checking bench of the axis data trace capture block
`timescale 1ns/1ps
module adtc_trace_tb;
  logic clk, nrst, reg_wr, reg_rd, tracing, irq, host_wr;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [12:0] host_addr;
  logic [15:0] host_wdata;
  logic [47:0] pos_cmd, motor_speed, motor_current, speed_cmd, follow_err;
  logic [2:0] axis_start, axis_error;
  int n_fail, compares, i;
  // rows: address beside expected read value after reset
  logic [39:0] rows [12] = '{
    {adtc_pkg::REG_CTRL, 32'h00000000}, {adtc_pkg::REG_CFG, 24'h000000, adtc_pkg::CFG_RST},
    {adtc_pkg::REG_INTERVAL, 23'h000000, adtc_pkg::INTERVAL_MIN},
    {adtc_pkg::REG_POINTS, 18'h00000, adtc_pkg::POINTS_MAX},
    {adtc_pkg::REG_CHSEL, 12'h000, adtc_pkg::CHSEL_RST}, {adtc_pkg::REG_STATUS, 32'h00000001},
    {adtc_pkg::REG_COUNT, 32'h00000000}, {adtc_pkg::REG_IRQ_STAT, 32'h00000000},
    {adtc_pkg::REG_IRQ_MASK, 32'h00000000}, {adtc_pkg::REG_RDADDR, 32'h00000000},
    {adtc_pkg::REG_RDLO, 32'h00000000}, {8'h30, 32'h00000000}};

  // clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  adtc_trace #(.UNIT_CYCLES(4)) u_adtc_trace (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .host_addr(host_addr), .host_wdata(host_wdata), .host_wr(host_wr), .pos_cmd(pos_cmd),
    .motor_speed(motor_speed), .motor_current(motor_current), .speed_cmd(speed_cmd),
    .follow_err(follow_err), .axis_start(axis_start), .axis_error(axis_error),
    .tracing(tracing), .irq(irq));

  adtc_host_model u_adtc_host_model (.clk(clk), .host_addr(host_addr),
    .host_wdata(host_wdata), .host_wr(host_wr), .axis_start(axis_start),
    .axis_error(axis_error));

  // comparisons
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // register bus cycles; read data lands in d
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // bounded poll until capture reports done
  task automatic wait_done;
    for (int k = 0; k < 100; k++) begin
      rd(adtc_pkg::REG_STATUS);
      if (d[2:1] === 2'b11) break;
    end
  endtask

  task automatic end_sim;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // watchdog
  initial begin
    #2000000;
    n_fail++;
    end_sim();
  end

  // main sequence
  initial begin
    nrst = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h00000000;
    pos_cmd = {16'h0a0a, 16'h0b0b, 16'h5555};
    motor_speed = {16'h0c0c, 16'h0d0d, 16'h1111};
    motor_current = {16'h0e0e, 16'h0f0f, 16'h2222};
    speed_cmd = {16'h1a1a, 16'h1b1b, 16'h3333};
    follow_err = {16'h1c1c, 16'h1d1d, 16'h4444};
    repeat (12) @(posedge clk);
    chk1(tracing, 1'b0);
    chk1(irq, 1'b0);
    chk32(reg_rdata, 32'h00000000);
    nrst <= 1'b1;
    // reset values, unmapped and locked reads
    for (i = 0; i < 12; i++) begin
      rd(rows[i][39:32]);
      chk32(d, rows[i][31:0]);
    end
    // unconditional start, point-count stop, mixed channel quantities
    wr(adtc_pkg::REG_IRQ_MASK, 32'h00000002);
    wr(adtc_pkg::REG_CHSEL, 32'h00082184);
    wr(adtc_pkg::REG_INTERVAL, 32'h00000002);
    wr(adtc_pkg::REG_POINTS, 32'h00000003);
    wr(adtc_pkg::REG_CFG, 32'h00000014);
    wr(adtc_pkg::REG_CTRL, 32'h00000001);
    repeat (3) @(posedge clk);
    chk1(tracing, 1'b1);
    wait_done();
    chk32(d, 32'h0000000e);
    rd(adtc_pkg::REG_COUNT);
    chk32(d, 32'h00000003);
    chk1(irq, 1'b1);
    wr(adtc_pkg::REG_RDADDR, 32'h00000002);
    repeat (2) @(posedge clk);
    rd(adtc_pkg::REG_RDLO);
    chk32(d, 32'h33331111);
    rd(adtc_pkg::REG_RDHI);
    chk32(d, 32'h44442222);
    wr(adtc_pkg::REG_IRQ_STAT, 32'h00000007);
    @(posedge clk);
    chk1(irq, 1'b0);
    // host trigger: wrong word ignored, trigger word starts capture
    wr(adtc_pkg::REG_CFG, 32'h0000001e);
    wr(adtc_pkg::REG_CTRL, 32'h00000001);
    repeat (10) @(posedge clk);
    chk1(tracing, 1'b0);
    u_adtc_host_model.mem_write(13'd5049, 16'h0001);
    repeat (4) @(posedge clk);
    chk1(tracing, 1'b0);
    u_adtc_host_model.mem_write(adtc_pkg::HOST_TRIG_WORD, adtc_pkg::HOST_TRIG_VAL);
    repeat (2) @(posedge clk);
    chk1(tracing, 1'b1);
    wr(adtc_pkg::REG_CTRL, 32'h00000002);
    @(posedge clk);
    chk1(tracing, 1'b0);
    // two axes, start signal on one only: point stop must not end the trace
    wr(adtc_pkg::REG_POINTS, 32'h00000001);
    wr(adtc_pkg::REG_INTERVAL, 32'h00000001);
    wr(adtc_pkg::REG_CFG, 32'h00000035);
    wr(adtc_pkg::REG_CTRL, 32'h00000001);
    u_adtc_host_model.set_pins(3'b001, 3'b000);
    repeat (10) @(posedge clk);
    chk1(tracing, 1'b1);
    repeat (40) @(posedge clk);
    chk1(tracing, 1'b1);
    wr(adtc_pkg::REG_CTRL, 32'h00000002);
    rd(adtc_pkg::REG_STATUS);
    chk32(d, 32'h0000000f);
    u_adtc_host_model.set_pins(3'b000, 3'b000);
    // error stop with masked then unmasked interrupt
    wr(adtc_pkg::REG_IRQ_MASK, 32'h00000000);
    wr(adtc_pkg::REG_IRQ_STAT, 32'h00000007);
    wr(adtc_pkg::REG_CFG, 32'h00000018);
    wr(adtc_pkg::REG_CTRL, 32'h00000001);
    repeat (4) @(posedge clk);
    u_adtc_host_model.set_pins(3'b000, 3'b001);
    repeat (12) @(posedge clk);
    chk1(tracing, 1'b0);
    rd(adtc_pkg::REG_IRQ_STAT);
    chk32(d & 32'h00000004, 32'h00000004);
    chk1(irq, 1'b0);
    wr(adtc_pkg::REG_IRQ_MASK, 32'h00000004);
    @(posedge clk);
    chk1(irq, 1'b1);
    wr(adtc_pkg::REG_IRQ_STAT, 32'h00000007);
    @(posedge clk);
    chk1(irq, 1'b0);
    u_adtc_host_model.set_pins(3'b000, 3'b000);
    // reduced variant: host trigger acts as unconditional
    wr(adtc_pkg::REG_CFG, 32'h000000fe);
    wr(adtc_pkg::REG_CTRL, 32'h00000001);
    repeat (4) @(posedge clk);
    chk1(tracing, 1'b1);
    wr(adtc_pkg::REG_CTRL, 32'h00000002);
    @(posedge clk);
    chk1(tracing, 1'b0);
    rd(adtc_pkg::REG_STATUS);
    chk32(d, 32'h0000001e);
    // reduced variant runs until the storage is full
    wr(adtc_pkg::REG_CTRL, 32'h00000001);
    repeat (33000) @(posedge clk);
    chk1(tracing, 1'b0);
    rd(adtc_pkg::REG_COUNT);
    chk32(d, 32'h00002000);
    wr(adtc_pkg::REG_RDADDR, 32'h00000000);
    repeat (2) @(posedge clk);
    rd(adtc_pkg::REG_RDLO);
    chk32(d, 32'h33333333);
    // reset in mid-capture
    wr(adtc_pkg::REG_CTRL, 32'h00000001);
    repeat (4) @(posedge clk);
    chk1(tracing, 1'b1);
    nrst <= 1'b0;
    @(posedge clk);
    chk1(tracing, 1'b0);
    chk1(irq, 1'b0);
    chk32(reg_rdata, 32'h00000000);
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rd(adtc_pkg::REG_CFG);
    chk32(d, {24'h000000, adtc_pkg::CFG_RST});
    rd(adtc_pkg::REG_STATUS);
    chk32(d, 32'h00000001);
    end_sim();
  end
endmodule // adtc_trace_tb
